// ===== core/scsi_initiator.sv
// initiator end: bus reset, arbitration, selection and byte handshakes with receive buffer
`timescale 1ns/10ps
`default_nettype none
module scsi_initiator #(
	parameter logic [scsi_bus_pkg::CNT_W-1:0] SEL_TIMEOUT_CYC = scsi_bus_pkg::SEL_TIMEOUT_CYC_DEF
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	scsi_bus_if.host                              bus,
	input  wire logic                             start,
	input  wire logic [scsi_bus_pkg::ID_W-1:0]    startId,
	input  wire logic                             busResetReq,
	input  wire logic                             atnReq,
	input  wire logic                             txValid,
	input  wire logic [scsi_bus_pkg::DATA_W-1:0]  txData,
	output var  logic                             txReady,
	output var  logic                             rxValid,
	output var  logic [scsi_bus_pkg::DATA_W-1:0]  rxData,
	input  wire logic                             rxReady,
	output var  logic [2:0]                       phase,
	output var  logic                             busy,
	output var  logic                             selFail
);
	import scsi_bus_pkg::*;

	typedef struct packed {
		host_state_type     st;
		lines_type          s1;
		lines_type          s2;
		lines_type          s3;
		lines_type          filt;
		lines_type          oeN;
		logic [CNT_W-1:0]   cnt;
		logic [ID_W-1:0]    tgt;
		logic               headV;
		logic [DATA_W-1:0]  headD;
		logic               tailV;
		logic [DATA_W-1:0]  tailD;
		logic               txReady;
		logic [2:0]         phase;
		logic               busy;
		logic               selFail;
	} host_reg_type;

	localparam host_reg_type H_INIT = '{st: H_RESET, s1: '1, s2: '1, s3: '1, filt: '1,
		oeN: LINES_IDLE, cnt: RST_CYC, default: '0};

	host_reg_type       r_reg;
	host_reg_type       r_next;
	logic               push;
	logic [DATA_W-1:0]  pushByte;
	logic               reqA;
	logic               ioA;
	logic               bsyA;

	// asserted levels of the target-driven lines, active low on the wire
	assign reqA = ~r_reg.filt[L_REQ];
	assign ioA  = ~r_reg.filt[L_IO];
	assign bsyA = ~r_reg.filt[L_BSY];

	// the host only ever pulls lines low; the enables carry all drive
	assign bus.hostOut = '0;
	assign bus.hostOeN = r_reg.oeN;

	// next-state logic for the whole initiator
	always_comb begin
		r_next = r_reg;
		push = 1'b0;
		pushByte = ~r_reg.filt[DATA_W-1:0];
		// three-stage input capture; a change counts once stages two and three agree
		r_next.s1 = bus.busLevel;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		r_next.selFail = 1'b0;
		// receive buffer drain side
		if (r_reg.headV && rxReady) begin
			r_next.headV = r_reg.tailV;
			r_next.headD = r_reg.tailD;
			r_next.tailV = 1'b0;
		end
		case (r_reg.st)
			H_RESET: begin
				// hold reset for the minimum time, then wait for the line to read high
				r_next.oeN = LINES_IDLE;
				if (r_reg.cnt != '0) begin
					r_next.oeN[L_RST] = 1'b0;
					r_next.cnt = r_reg.cnt - 1'b1;
				end else if (r_reg.filt[L_RST]) begin
					r_next.st = H_FREE;
				end
			end
			H_FREE: begin
				r_next.oeN = LINES_IDLE;
				// leave bus free only for arbitration, and only when bus is idle
				if (start && r_reg.filt[L_BSY] && r_reg.filt[L_SEL]) begin
					r_next.st = H_ARB;
					r_next.tgt = startId;
					r_next.oeN[L_BSY] = 1'b0;
					r_next.oeN[DATA_W-1:0] = ~HOST_BIT;
					r_next.cnt = ARB_CYC;
				end
			end
			H_ARB: begin
				r_next.cnt = r_reg.cnt - 1'b1;
				if (r_reg.cnt == '0) begin
					// a higher ID on the data lines or a foreign select loses
					if (((~r_reg.filt[DATA_W-1:0] & HIGHER_MASK) == '0)
						&& r_reg.filt[L_SEL]) begin
						r_next.st = H_SEL;
						r_next.oeN[L_SEL] = 1'b0;
						r_next.oeN[DATA_W-1:0] = ~(HOST_BIT | (8'h01 << r_reg.tgt));
						r_next.cnt = SETTLE_CYC;
					end else begin
						r_next.st = H_FREE;
						r_next.oeN = LINES_IDLE;
					end
				end
			end
			H_SEL: begin
				// after settling, let go of busy so the target can answer with it
				r_next.cnt = r_reg.cnt - 1'b1;
				if (r_reg.cnt == '0) begin
					r_next.oeN[L_BSY] = 1'b1;
					r_next.st = H_SELW;
					r_next.cnt = SEL_TIMEOUT_CYC;
				end
			end
			H_SELW: begin
				r_next.cnt = r_reg.cnt - 1'b1;
				// skip the stale busy still in the input stages after our release
				if (bsyA && (r_reg.cnt <= SEL_TIMEOUT_CYC - SETTLE_CYC)) begin
					r_next.oeN[L_SEL] = 1'b1;
					r_next.oeN[DATA_W:0] = '1;
					r_next.st = H_XFER;
				end else if (r_reg.cnt == '0) begin
					r_next.oeN = LINES_IDLE;
					r_next.st = H_FREE;
					r_next.selFail = 1'b1;
				end
			end
			H_XFER: begin
				// the target steers every phase; the host only answers requests
				if (!bsyA) begin
					r_next.st = H_FREE;
					r_next.oeN = LINES_IDLE;
				end else if (reqA && ioA) begin
					// inbound byte: take it only if the buffer has room, else stall ack
					if (!r_reg.tailV) begin
						push = 1'b1;
						r_next.oeN[L_ACK] = 1'b0;
						r_next.st = H_ACKW;
					end
				end else if (reqA && r_reg.txReady && txValid) begin
					r_next.oeN[DATA_W:0] = dataOeN(txData);
					r_next.cnt = SETTLE_CYC;
					r_next.st = H_SETUP;
				end
			end
			H_SETUP: begin
				// outbound data settles on the lines before acknowledge
				r_next.cnt = r_reg.cnt - 1'b1;
				if (r_reg.cnt == '0) begin
					r_next.oeN[L_ACK] = 1'b0;
					r_next.st = H_ACKW;
				end
			end
			H_ACKW: begin
				// close the exchange once the target drops its request
				if (!reqA) begin
					r_next.oeN[L_ACK] = 1'b1;
					r_next.oeN[DATA_W:0] = '1;
					r_next.st = H_XFER;
				end
			end
			default: begin
				r_next.st = H_FREE;
				r_next.oeN = LINES_IDLE;
			end
		endcase
		// receive buffer fill side; ready is the empty tail slot
		if (push) begin
			if (!r_next.headV) begin
				r_next.headV = 1'b1;
				r_next.headD = pushByte;
			end else begin
				r_next.tailV = 1'b1;
				r_next.tailD = pushByte;
			end
		end
		// a reset seen on the bus abandons everything in flight
		if (!r_reg.filt[L_RST] && (r_reg.st != H_RESET)) begin
			r_next.st = H_FREE;
			r_next.oeN = LINES_IDLE;
			r_next.headV = 1'b0;
			r_next.tailV = 1'b0;
		end
		if (busResetReq) begin
			r_next.st = H_RESET;
			r_next.cnt = RST_CYC;
		end
		// attention follows the request while connected or selecting
		r_next.oeN[L_ATN] = ~(atnReq && (r_next.st >= H_SEL));
		// never drive target-only lines; the host is never a target
		r_next.oeN[L_CD] = 1'b1;
		r_next.oeN[L_IO] = 1'b1;
		r_next.oeN[L_MSG] = 1'b1;
		r_next.oeN[L_REQ] = 1'b1;
		r_next.txReady = (r_next.st == H_XFER) && bsyA && reqA && !ioA;
		r_next.phase = 3'h0;
		if (r_next.st == H_XFER) begin
			r_next.phase = {~r_reg.filt[L_MSG], ~r_reg.filt[L_CD], ~r_reg.filt[L_IO]};
		end
		r_next.busy = (r_next.st != H_FREE);
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_reg <= H_INIT;
		end else begin
			r_reg <= r_next;
		end
	end

	// user-side outputs straight from the state register
	assign txReady = r_reg.txReady;
	assign rxValid = r_reg.headV;
	assign rxData  = r_reg.headD;
	assign phase   = r_reg.phase;
	assign busy    = r_reg.busy;
	assign selFail = r_reg.selFail;
endmodule : scsi_initiator
`default_nettype wire

// ===== inc/scsi_bus_pkg.sv
// shared constants, line map, types and parity helpers for the parallel bus
package scsi_bus_pkg;
	localparam int LINES  = 18;
	localparam int DATA_W = 8;
	localparam int ID_W   = 3;
	localparam int CNT_W  = 16;
	// bit positions of each bus line in a line vector; data bits sit at 0..7
	localparam int L_PAR = 8;
	localparam int L_BSY = 9;
	localparam int L_SEL = 10;
	localparam int L_CD  = 11;
	localparam int L_IO  = 12;
	localparam int L_MSG = 13;
	localparam int L_REQ = 14;
	localparam int L_ACK = 15;
	localparam int L_ATN = 16;
	localparam int L_RST = 17;
	// positions in a three-bit phase code
	localparam int PH_IO  = 0;
	localparam int PH_CD  = 1;
	localparam int PH_MSG = 2;
	localparam int HOST_ID = 7;
	localparam logic [DATA_W-1:0] HOST_BIT    = 8'(16'h0001 << HOST_ID);
	localparam logic [DATA_W-1:0] HIGHER_MASK = 8'(16'hFFFF << (HOST_ID + 1));
	localparam logic [LINES-1:0]  LINES_IDLE  = 18'h3FFFF;
	// timing in its own unit and the derived cycle counts at the local clock
	localparam int CLK_MHZ        = 40;
	localparam int RST_HOLD_NS    = 25000;
	localparam int ARB_DELAY_NS   = 2400;
	localparam int SETTLE_NS      = 400;
	localparam int SEL_TIMEOUT_NS = 1000000;
	localparam logic [CNT_W-1:0] RST_CYC    = CNT_W'((RST_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] ARB_CYC    = CNT_W'((ARB_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CNT_W-1:0] SEL_TIMEOUT_CYC_DEF =
		CNT_W'((SEL_TIMEOUT_NS * CLK_MHZ + 999) / 1000);
	typedef logic [LINES-1:0] lines_type;
	typedef enum logic [2:0] {
		H_RESET = 3'h0, H_FREE = 3'h1, H_ARB = 3'h2, H_SEL = 3'h3,
		H_SELW = 3'h4, H_XFER = 3'h5, H_SETUP = 3'h6, H_ACKW = 3'h7
	} host_state_type;
	typedef enum logic [2:0] {
		T_IDLE = 3'h0, T_SELW = 3'h1, T_CONN = 3'h2, T_DRIVE = 3'h3,
		T_REQ = 3'h4, T_REL = 3'h5
	} target_state_type;
	// odd parity: the parity line is asserted when the byte has an even count of ones
	function automatic logic oddPar(input logic [DATA_W-1:0] b);
		return ~^b;
	endfunction : oddPar
	// enables for data and parity lines: low where the line is pulled low
	function automatic logic [DATA_W:0] dataOeN(input logic [DATA_W-1:0] b);
		return ~{oddPar(b), b};
	endfunction : dataOeN
endpackage : scsi_bus_pkg

// ===== inc/scsi_bus_if.sv
// wired-and bus between initiator and target, resolved from the drive enables
`timescale 1ns/10ps
`default_nettype none
interface scsi_bus_if;
	import scsi_bus_pkg::*;
	lines_type hostOut;
	lines_type hostOeN;
	lines_type targetOut;
	lines_type targetOeN;
	lines_type busLevel;
	// a line is low when either party enables its low drive
	assign busLevel = (hostOeN | hostOut) & (targetOeN | targetOut);
	modport host   (input busLevel, output hostOut, output hostOeN);
	modport target (input busLevel, output targetOut, output targetOeN);
endinterface : scsi_bus_if
`default_nettype wire

// ===== core/scsi_target.sv
// target end: answers selection, drives phase lines and opens each byte handshake
`timescale 1ns/10ps
`default_nettype none
module scsi_target (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	scsi_bus_if.target                            bus,
	input  wire logic [scsi_bus_pkg::ID_W-1:0]    myId,
	input  wire logic [2:0]                       phaseIn,
	input  wire logic                             releaseConn,
	input  wire logic                             txValid,
	input  wire logic [scsi_bus_pkg::DATA_W-1:0]  txData,
	output var  logic                             txReady,
	output var  logic                             rxValid,
	output var  logic [scsi_bus_pkg::DATA_W-1:0]  rxData,
	input  wire logic                             rxReady,
	output var  logic                             selected,
	output var  logic                             atnSeen
);
	import scsi_bus_pkg::*;

	typedef struct packed {
		target_state_type   st;
		lines_type          s1;
		lines_type          s2;
		lines_type          s3;
		lines_type          filt;
		lines_type          oeN;
		logic [CNT_W-1:0]   cnt;
		logic [2:0]         phase;
		logic               rxV;
		logic [DATA_W-1:0]  rxD;
		logic               txReady;
		logic               selected;
		logic               atnSeen;
	} target_reg_type;

	localparam target_reg_type T_INIT = '{st: T_IDLE, s1: '1, s2: '1, s3: '1, filt: '1,
		oeN: LINES_IDLE, default: '0};

	target_reg_type r_reg;
	target_reg_type r_next;
	logic           ackA;

	assign ackA = ~r_reg.filt[L_ACK];
	assign bus.targetOut = '0;
	assign bus.targetOeN = r_reg.oeN;

	// next-state logic for the target
	always_comb begin
		r_next = r_reg;
		r_next.s1 = bus.busLevel;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		if (r_reg.rxV && rxReady) begin
			r_next.rxV = 1'b0;
		end
		case (r_reg.st)
			T_IDLE: begin
				// selected when select is low, busy released and our ID bit is low
				r_next.oeN = LINES_IDLE;
				if (!r_reg.filt[L_SEL] && r_reg.filt[L_BSY] && !r_reg.filt[myId]) begin
					r_next.oeN[L_BSY] = 1'b0;
					r_next.st = T_SELW;
				end
			end
			T_SELW: begin
				if (r_reg.filt[L_SEL]) begin
					r_next.st = T_CONN;
				end
			end
			T_CONN: begin
				// phase lines follow the user code between bytes
				r_next.phase = phaseIn;
				if (releaseConn) begin
					r_next.st = T_IDLE;
					r_next.oeN = LINES_IDLE;
				end else if (r_reg.txReady && txValid) begin
					r_next.oeN[DATA_W:0] = dataOeN(txData);
					r_next.cnt = SETTLE_CYC;
					r_next.st = T_DRIVE;
				end else if (!phaseIn[PH_IO] && rxReady && !r_reg.rxV) begin
					r_next.cnt = SETTLE_CYC;
					r_next.st = T_DRIVE;
				end
			end
			T_DRIVE: begin
				// data and phase settle before the request opens the exchange
				r_next.cnt = r_reg.cnt - 1'b1;
				if (r_reg.cnt == '0) begin
					r_next.oeN[L_REQ] = 1'b0;
					r_next.st = T_REQ;
				end
			end
			T_REQ: begin
				if (ackA) begin
					if (!r_reg.phase[PH_IO]) begin
						r_next.rxV = 1'b1;
						r_next.rxD = ~r_reg.filt[DATA_W-1:0];
					end
					r_next.oeN[L_REQ] = 1'b1;
					r_next.oeN[DATA_W:0] = '1;
					r_next.st = T_REL;
				end
			end
			T_REL: begin
				// next byte waits for the acknowledge to drop
				if (!ackA) begin
					r_next.st = T_CONN;
				end
			end
			default: begin
				r_next.st = T_IDLE;
				r_next.oeN = LINES_IDLE;
			end
		endcase
		// bus reset returns the target to idle with every line released
		if (!r_reg.filt[L_RST]) begin
			r_next.st = T_IDLE;
			r_next.oeN = LINES_IDLE;
			r_next.rxV = 1'b0;
		end
		// phase lines are driven only while connected; reset is never driven
		if (r_next.st >= T_CONN) begin
			r_next.oeN[L_IO] = ~r_next.phase[PH_IO];
			r_next.oeN[L_CD] = ~r_next.phase[PH_CD];
			r_next.oeN[L_MSG] = ~r_next.phase[PH_MSG];
		end
		r_next.oeN[L_RST] = 1'b1;
		r_next.txReady = (r_next.st == T_CONN) && phaseIn[PH_IO];
		r_next.selected = (r_next.st >= T_CONN);
		r_next.atnSeen = ~r_reg.filt[L_ATN];
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r_reg <= T_INIT;
		end else begin
			r_reg <= r_next;
		end
	end

	// user-side outputs straight from the state register
	assign txReady  = r_reg.txReady;
	assign rxValid  = r_reg.rxV;
	assign rxData   = r_reg.rxD;
	assign selected = r_reg.selected;
	assign atnSeen  = r_reg.atnSeen;
endmodule : scsi_target
`default_nettype wire

// ===== testbench/scsi1_bus_phase_control_asserts.sv
// concurrent checks on the bus lines between the initiator and target ends
`timescale 1ns/10ps
`default_nettype none
module scsi1_bus_phase_control_asserts (
	input wire logic                    clk_sys,
	input wire logic                    rst,
	input wire scsi_bus_pkg::lines_type hostOut,
	input wire scsi_bus_pkg::lines_type hostOeN,
	input wire scsi_bus_pkg::lines_type targetOut,
	input wire scsi_bus_pkg::lines_type targetOeN,
	input wire scsi_bus_pkg::lines_type busLevel
);
	import scsi_bus_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// parties only ever pull lines low
	property p_pullOnly;
		hostOut == '0 && targetOut == '0;
	endproperty
	a_pullOnly: assert property (p_pullOnly) else $error("line driven high");
	// phase and request lines belong to the target
	property p_hostKeepsOff;
		&{hostOeN[L_REQ], hostOeN[L_CD], hostOeN[L_IO], hostOeN[L_MSG]};
	endproperty
	a_hostKeepsOff: assert property (p_hostKeepsOff)
		else $error("host drove a target line");
	// acknowledge and attention belong to the initiator
	property p_targetNoAck;
		targetOeN[L_ACK] && targetOeN[L_ATN];
	endproperty
	a_targetNoAck: assert property (p_targetNoAck)
		else $error("target drove ack or atn");
	// the target never resets the bus
	property p_targetNoRst;
		targetOeN[L_RST];
	endproperty
	a_targetNoRst: assert property (p_targetNoRst) else $error("target drove bus reset");
	// no reselection: the target never selects
	property p_targetNoSel;
		targetOeN[L_SEL];
	endproperty
	a_targetNoSel: assert property (p_targetNoSel) else $error("target drove select");
	// arbitration shows busy and only the host bit
	property p_arbOwnId;
		!hostOeN[L_BSY] && hostOeN[L_SEL] |-> hostOeN[7:0] == 8'h7F;
	endproperty
	a_arbOwnId: assert property (p_arbOwnId) else $error("wrong id in arbitration");
	// select only after the full arbitration delay with busy held
	property p_selAfterArb;
		$fell(hostOeN[L_SEL]) |-> !hostOeN[L_BSY] && !hostOeN[7] && !$past(hostOeN[L_BSY], 96);
	endproperty
	a_selAfterArb: assert property (p_selAfterArb) else $error("select too early");
	// arbitration starts only from a free bus
	property p_freeToArb;
		$fell(hostOeN[L_BSY]) |-> $past(busLevel[L_BSY]) && $past(busLevel[L_SEL]);
	endproperty
	a_freeToArb: assert property (p_freeToArb) else $error("arbitration on busy bus");
	// acknowledge is raised only while request is asserted
	property p_ackAfterReq;
		$fell(hostOeN[L_ACK]) |-> !busLevel[L_REQ];
	endproperty
	a_ackAfterReq: assert property (p_ackAfterReq) else $error("ack without req");
	// acknowledge drops only after request has dropped
	property p_ackDrop;
		$rose(hostOeN[L_ACK]) |-> busLevel[L_REQ];
	endproperty
	a_ackDrop: assert property (p_ackDrop) else $error("ack dropped early");
	// request drops only after acknowledge is seen
	property p_reqDrop;
		$rose(targetOeN[L_REQ]) |-> !busLevel[L_ACK];
	endproperty
	a_reqDrop: assert property (p_reqDrop) else $error("req dropped early");
	// data settles before request rises
	property p_dataFirst;
		$fell(targetOeN[L_REQ]) |-> targetOeN[8:0] == $past(targetOeN[8:0], 16);
	endproperty
	a_dataFirst: assert property (p_dataFirst) else $error("data moved before req");
	// outbound bytes carry odd parity over nine lines
	property p_hostParity;
		!hostOeN[L_ACK] && busLevel[L_IO] |-> ^(~hostOeN[8:0]);
	endproperty
	a_hostParity: assert property (p_hostParity) else $error("bad parity from host");
	// bus reset releases every target line
	property p_rstClears;
		$fell(busLevel[L_RST]) |-> ##[1:8] (&targetOeN);
	endproperty
	a_rstClears: assert property (p_rstClears) else $error("target held lines in reset");
	// host resets the bus right after startup
	property p_startRst;
		$fell(rst) |-> ##[0:2] !hostOeN[L_RST];
	endproperty
	a_startRst: assert property (p_startRst) else $error("no bus reset at startup");
endmodule : scsi1_bus_phase_control_asserts
`default_nettype wire

// ===== testbench/scsi1_bus_phase_control_tb_top.sv
// self-checking bench: initiator and target joined over the shared bus
`timescale 1ns/10ps
`default_nettype none
module scsi1_bus_phase_control_tb_top;
	import scsi_bus_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       start, busResetReq, atnReq, iTxValid, iTxReady, iRxValid, iRxReady;
	logic       busy, selFail, releaseConn, tTxValid, tTxReady, tRxValid, tRxReady;
	logic       selected, atnSeen;
	logic [2:0] startId, tId, tPhase, phase;
	logic [7:0] iTxData, iRxData, tTxData, tRxData;
	logic [7:0] d [4];
	logic [2:0] codes [6] = '{3'h2, 3'h1, 3'h0, 3'h3, 3'h7, 3'h6};
	logic [31:0] seed = 32'h00000029;
	int         failures = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	int         n;
	scsi_bus_if busIf();
	scsi_initiator #(.SEL_TIMEOUT_CYC(16'h0040)) u_scsi_initiator (.clk_sys(clk_sys), .rst(rst),
		.bus(busIf), .start(start), .startId(startId), .busResetReq(busResetReq),
		.atnReq(atnReq), .txValid(iTxValid), .txData(iTxData), .txReady(iTxReady),
		.rxValid(iRxValid), .rxData(iRxData), .rxReady(iRxReady), .phase(phase),
		.busy(busy), .selFail(selFail));
	scsi_target u_scsi_target (.clk_sys(clk_sys), .rst(rst), .bus(busIf), .myId(tId),
		.phaseIn(tPhase), .releaseConn(releaseConn), .txValid(tTxValid), .txData(tTxData),
		.txReady(tTxReady), .rxValid(tRxValid), .rxData(tRxData), .rxReady(tRxReady),
		.selected(selected), .atnSeen(atnSeen));
	scsi1_bus_phase_control_asserts chk (.clk_sys(clk_sys), .rst(rst),
		.hostOut(busIf.hostOut), .hostOeN(busIf.hostOeN), .targetOut(busIf.targetOut),
		.targetOeN(busIf.targetOeN), .busLevel(busIf.busLevel));
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			complete_run();
		end
	end
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nxt
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// one byte offered on the target (inb) or host side until taken
	task automatic push(input logic inb, input logic [7:0] v);
		@(negedge clk_sys);
		if (inb) begin
			tTxValid = 1'b1;
			tTxData = v;
		end else begin
			iTxValid = 1'b1;
			iTxData = v;
		end
		while ((inb ? tTxReady : iTxReady) !== 1'b1) @(negedge clk_sys);
		@(negedge clk_sys);
		tTxValid = 1'b0;
		iTxValid = 1'b0;
	endtask : push
	// host pops one buffered byte
	task automatic popHost(input logic [7:0] e);
		while (iRxValid !== 1'b1) @(negedge clk_sys);
		check(iRxData, e, "inbound byte");
		iRxReady = 1'b1;
		@(negedge clk_sys);
		iRxReady = 1'b0;
		@(negedge clk_sys);
	endtask : popHost
	task automatic popTarget(input logic [7:0] e);
		while (tRxValid !== 1'b1) @(negedge clk_sys);
		check(tRxData, e, "outbound byte");
		@(negedge clk_sys);
	endtask : popTarget
	task automatic connect(input logic [2:0] id, output int cnt);
		startId = id;
		start = 1'b1;
		cnt = 0;
		// hold the request until the initiator leaves bus free; stale inputs may refuse it
		while (busy !== 1'b1 && cnt < 40) begin
			@(negedge clk_sys);
			cnt++;
		end
		start = 1'b0;
		cnt = 0;
		while (selected !== 1'b1 && selFail !== 1'b1 && cnt < 400) begin
			@(negedge clk_sys);
			cnt++;
		end
	endtask : connect
	task automatic waitFree(output int cnt);
		cnt = 0;
		while (busy !== 1'b0) begin
			@(negedge clk_sys);
			cnt++;
		end
	endtask : waitFree
	// main sequence
	initial begin
		{start, busResetReq, atnReq, iTxValid, iRxReady, releaseConn, tTxValid} = '0;
		{startId, tPhase, iTxData, tTxData, tRxReady} = '0;
		tId = 3'(nxt() % 7);
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		check(8'(busIf.busLevel[L_RST]), 8'h00, "no startup bus reset");
		waitFree(n);
		check(8'(n >= int'(RST_CYC)), 8'h01, "bus reset too short");
		connect((tId == 3'h6) ? 3'h0 : tId + 3'h1, n);
		check(8'(selFail), 8'h01, "absent unit answered");
		check(8'(selected), 8'h00, "wrong unit selected");
		waitFree(n);
		connect(tId, n);
		check(8'(selected), 8'h01, "target not selected");
		for (int c = 0; c < 6; c++) begin
			tPhase = codes[c];
			if (c == 5) begin
				atnReq = 1'b1;
				n = 0;
				while (atnSeen !== 1'b1 && n < 20) begin
					@(negedge clk_sys);
					n++;
				end
				check(8'(atnSeen), 8'h01, "attention not seen");
			end
			d[0] = 8'h00;
			d[1] = 8'hFF;
			d[2] = 8'(nxt());
			d[3] = 8'(nxt());
			if (codes[c][PH_IO]) begin
				fork
					for (int k = 0; k < 4; k++) push(1'b1, d[k]);
					begin
						repeat (300) @(negedge clk_sys);
						for (int k = 0; k < 4; k++) popHost(d[k]);
					end
				join
			end else begin
				// the target asks for out bytes only while its receiver is ready
				tRxReady = 1'b1;
				fork
					for (int k = 0; k < 4; k++) push(1'b0, d[k]);
					for (int k = 0; k < 4; k++) popTarget(d[k]);
				join
				tRxReady = 1'b0;
			end
			// the host reports the phase only once the last handshake has closed
			repeat (16) @(negedge clk_sys);
			check(8'(phase), 8'(codes[c]), "phase lines");
		end
		atnReq = 1'b0;
		busResetReq = 1'b1;
		@(negedge clk_sys);
		busResetReq = 1'b0;
		repeat (20) @(negedge clk_sys);
		check(8'(selected), 8'h00, "connection kept over bus reset");
		waitFree(n);
		connect(tId, n);
		releaseConn = 1'b1;
		while (selected !== 1'b0) @(negedge clk_sys);
		releaseConn = 1'b0;
		waitFree(n);
		check(8'(n < 20), 8'h01, "bus free not seen");
		complete_run();
	end
endmodule : scsi1_bus_phase_control_tb_top
`default_nettype wire
